// [oca_defines.vh]
// constants for the character attribute colour-out block
// assumes inclusion by bare name from the design file
`ifndef OCA_DEFINES_VH
`define OCA_DEFINES_VH
// ----------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------
`define OCA_IDX_ATTR 8'h98
`define OCA_IDX_CODE 8'h99
`define OCA_IDX_PTR 8'h9A
`define OCA_IDX_STAT 8'hA0
`define OCA_IDX_MODE 8'hC1
// ----------------------------------------
// reset values
// ----------------------------------------
`define OCA_RST_ATTR 8'h00
`define OCA_RST_PTR 7'h00
`define OCA_RST_MODE 2'h0
`define OCA_RST_BG 3'h0
// ----------------------------------------
// special character codes
// ----------------------------------------
`define OCA_CODE_NL 6'h3D
`define OCA_CODE_SPACE 6'h3C
`define OCA_CODE_BG_CHANGE_SPACE 6'h3E
`define OCA_CODE_SPLIT 6'h3F
// ----------------------------------------
// attribute field positions
// ----------------------------------------
`define OCA_ATTR_E 4
`define OCA_ATTR_B 4
`define OCA_ATTR_SR 2
`define OCA_ATTR_D 1
`define OCA_ATTR_SH 0
`define OCA_PACK_E 3
`define OCA_MODE_LSB 4
// ----------------------------------------
// geometry
// ----------------------------------------
`define OCA_ROW_LINES 6'h12
`define OCA_SHORT_LINES 6'h04
`define OCA_CELL_DOTS 5'h0E
`define OCA_HALF_DOT 4'h7
`endif

// [oca_colour_out.v]
// character attribute decode and colour output for the on-screen display
// assumes an external glyph rom answering cg_addr_o combinationally,
// and sync inputs active high from pins of another domain
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/10ps
`include "oca_defines.vh"

// Summary of operation
// - four special codes: row end, spaces
// - attribute meaning depends on character code
// - end flag stops rows for field
// - short row is 4 or 8 lines
// - double flag doubles next row size
// - shadow flag shadows next row characters
// - attribute B picks background or video
// - background spaces load background colour
// - ordinary characters carry foreground colour
// - row controls cleared at vertical scan
// - every row end advances vertical position
// - split space changes at half cell
// - plain space keeps background colour
// - background colour kept across fields
// - background update needs mode one or more
// - bit map selects foreground or background
// - background on outputs except listed times
// - attribute write latches, code write stores
// - address pointer increments after code write
// - background space acts at left edge
module oca_colour_out #(
   parameter RAM_DEPTH = 128
) (
   input wire mclk_i,
   input wire rst_b_i,
   input wire [7:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   output wire [31:0] avs_readdata_o,
   output wire avs_waitrequest_o,
   input wire hsync_i,
   input wire vsync_i,
   input wire [13:0] cg_bits_i,
   output wire [10:0] cg_addr_o,
   output wire [2:0] colour_out_bus_o,
   output wire overlay_select_out_o
);

   // ----------------------------------------
   // reset release
   // ----------------------------------------
   reg rst_s1_q;
   reg rst_s2_q;
   always @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   wire rst_b = rst_s2_q;

   // ----------------------------------------
   // sync inputs: three flops, change once last two agree
   // ----------------------------------------
   reg [2:0] hs_sh_q;
   reg [2:0] vs_sh_q;
   reg hs_q;
   reg vs_q;
   always @(posedge mclk_i or negedge rst_b) begin
      if (!rst_b) begin
         hs_sh_q <= 3'h0;
         vs_sh_q <= 3'h0;
         hs_q <= 1'b0;
         vs_q <= 1'b0;
      end else begin
         hs_sh_q <= {hs_sh_q[1:0], hsync_i};
         vs_sh_q <= {vs_sh_q[1:0], vsync_i};
         if (hs_sh_q[1] == hs_sh_q[2]) begin
            hs_q <= hs_sh_q[2];
         end
         if (vs_sh_q[1] == vs_sh_q[2]) begin
            vs_q <= vs_sh_q[2];
         end
      end
   end

   // ----------------------------------------
   // synced edges: both late flops must agree first
   // ----------------------------------------
   wire hs_rise = hs_sh_q[1] & hs_sh_q[2] & ~hs_q;
   wire hs_fall = ~hs_sh_q[1] & ~hs_sh_q[2] & hs_q;
   wire vs_rise = vs_sh_q[1] & vs_sh_q[2] & ~vs_q;

   // ----------------------------------------
   // register bus
   // ----------------------------------------
   reg wait_q;
   reg [31:0] rdata_q;
   reg [7:0] attr_q;
   reg [6:0] ptr_q;
   reg [1:0] mode_q;
   reg [9:0] ram [0:RAM_DEPTH-1];
   reg end_q;
   reg [2:0] bg_col_q;
   reg [31:0] rd_mux;

   wire req = avs_read_i | avs_write_i;
   wire commit = avs_write_i & ~wait_q;

   always @* begin
      case (avs_address_i)
         `OCA_IDX_ATTR: rd_mux = {24'h000000, attr_q};
         `OCA_IDX_PTR: rd_mux = {25'h0000000, ptr_q};
         `OCA_IDX_MODE: rd_mux = {26'h0000000, mode_q, 4'h0};
         `OCA_IDX_STAT: rd_mux = {26'h0000000, end_q, vs_q, hs_q, bg_col_q};
         default: rd_mux = 32'h00000000;
      endcase
   end

   always @(posedge mclk_i or negedge rst_b) begin
      if (!rst_b) begin
         wait_q <= 1'b1;
         rdata_q <= 32'h00000000;
         attr_q <= `OCA_RST_ATTR;
         ptr_q <= `OCA_RST_PTR;
         mode_q <= `OCA_RST_MODE;
      end else begin
         // one wait cycle, then answer; request released after it
         if (req && wait_q) begin
            wait_q <= 1'b0;
            rdata_q <= avs_read_i ? rd_mux : 32'h00000000;
         end else begin
            wait_q <= 1'b1;
         end
         if (commit) begin
            case (avs_address_i)
               `OCA_IDX_ATTR: attr_q <= avs_writedata_i[7:0];
               `OCA_IDX_CODE: ptr_q <= ptr_q + 7'h01;
               `OCA_IDX_PTR: ptr_q <= avs_writedata_i[6:0];
               `OCA_IDX_MODE: mode_q <= avs_writedata_i[5:4];
               default: ptr_q <= ptr_q;
            endcase
         end
      end
   end

   // ----------------------------------------
   // display memory
   // ----------------------------------------
   // display memory: only B/E, SR, D/Sh or colour bits kept
   always @(posedge mclk_i) begin
      if (commit && avs_address_i == `OCA_IDX_CODE) begin
         ram[ptr_q] <= {attr_q[4], attr_q[2:0], avs_writedata_i[5:0]};
      end
   end

   assign avs_waitrequest_o = wait_q;
   assign avs_readdata_o = rdata_q;

   // ----------------------------------------
   // row and scan state
   // ----------------------------------------
   reg sr_q;
   reg dbl_q;
   reg sh_q;
   reg [5:0] line_q;
   reg [6:0] row_ptr_q;
   reg [6:0] scan_ptr_q;
   reg prime_q;
   reg walk_q;
   reg nl_seen_q;
   reg [6:0] nl_ptr_q;
   reg [3:0] nl_attr_q;
   reg [4:0] dot_q;
   reg [5:0] cell_code_q;
   reg [3:0] cell_attr_q;
   reg cell_b_q;
   reg prev_bit_q;
   reg [10:0] cg_addr_q;
   reg [2:0] col_q;
   reg ov_q;

   // ----------------------------------------
   // character fetch and cell geometry
   // ----------------------------------------
   wire [9:0] nxt = ram[scan_ptr_q];
   wire [5:0] nxt_code = nxt[5:0];
   wire [3:0] nxt_attr = nxt[9:6];
   wire mode_on = (mode_q != 2'h0);
   wire [4:0] last_dot = dbl_q ? 5'h1B : (`OCA_CELL_DOTS - 5'h01);
   wire load = prime_q | (walk_q & (dot_q == last_dot));
   wire [3:0] px = dbl_q ? dot_q[4:1] : dot_q[3:0];
   wire [4:0] glyph_line = dbl_q ? line_q[5:1] : line_q[4:0];
   wire [5:0] base_lines = sr_q ? `OCA_SHORT_LINES : `OCA_ROW_LINES;
   wire [5:0] row_lines = dbl_q ? {base_lines[4:0], 1'b0} : base_lines;
   wire [5:0] line_inc = line_q + 6'h01;
   wire nl_end = nl_attr_q[`OCA_PACK_E];
   // last dot of the left half, so both halves of a split cell match
   wire half_last = (px == `OCA_HALF_DOT - 4'h1) & (!dbl_q | dot_q[0]);
   wire split_mid = (cell_code_q == `OCA_CODE_SPLIT) & half_last;

   function is_space;
      input [5:0] code;
      begin
         is_space = (code == `OCA_CODE_SPACE) | (code == `OCA_CODE_BG_CHANGE_SPACE) |
            (code == `OCA_CODE_SPLIT);
      end
   endfunction

   wire cell_bit = is_space(cell_code_q) ? 1'b0 : cg_bits_i[4'hD - px];

   // ----------------------------------------
   // row and field walk
   // ----------------------------------------

   always @(posedge mclk_i or negedge rst_b) begin
      if (!rst_b) begin
         end_q <= 1'b0;
         sr_q <= 1'b0;
         dbl_q <= 1'b0;
         sh_q <= 1'b0;
         line_q <= 6'h00;
         row_ptr_q <= 7'h00;
         scan_ptr_q <= 7'h00;
         prime_q <= 1'b0;
         walk_q <= 1'b0;
         nl_seen_q <= 1'b0;
         nl_ptr_q <= 7'h00;
         nl_attr_q <= 4'h0;
         dot_q <= 5'h00;
         cell_code_q <= `OCA_CODE_SPACE;
         cell_attr_q <= 4'h0;
         cell_b_q <= 1'b0;
         bg_col_q <= `OCA_RST_BG;
         cg_addr_q <= 11'h000;
      end else begin
         prime_q <= 1'b0;
         if (vs_rise) begin
            // row controls reset each field; background colour survives
            end_q <= 1'b0;
            sr_q <= 1'b0;
            dbl_q <= 1'b0;
            sh_q <= 1'b0;
            line_q <= 6'h00;
            row_ptr_q <= 7'h00;
            walk_q <= 1'b0;
         end else if (hs_fall) begin
            scan_ptr_q <= row_ptr_q;
            nl_seen_q <= 1'b0;
            prime_q <= mode_on & ~end_q & ~vs_q;
         end else if (hs_rise) begin
            walk_q <= 1'b0;
            if (!end_q && mode_on && !vs_q) begin
               if (line_inc >= row_lines) begin
                  line_q <= 6'h00;
                  // each row end moves down, even a leading one
                  row_ptr_q <= nl_ptr_q;
                  if (!nl_seen_q || nl_end) begin
                     end_q <= 1'b1;
                  end else begin
                     sr_q <= nl_attr_q[`OCA_ATTR_SR];
                     dbl_q <= nl_attr_q[`OCA_ATTR_D];
                     sh_q <= nl_attr_q[`OCA_ATTR_SH];
                  end
               end else begin
                  line_q <= line_inc;
               end
            end
         end else if (load) begin
            dot_q <= 5'h00;
            if (nxt_code == `OCA_CODE_NL) begin
               walk_q <= 1'b0;
               nl_seen_q <= 1'b1;
               nl_ptr_q <= scan_ptr_q + 7'h01;
               nl_attr_q <= nxt_attr;
            end else begin
               walk_q <= 1'b1;
               scan_ptr_q <= scan_ptr_q + 7'h01;
               cell_code_q <= nxt_code;
               cell_attr_q <= nxt_attr;
               cg_addr_q <= {nxt_code, glyph_line};
               if (nxt_code == `OCA_CODE_BG_CHANGE_SPACE) begin
                  if (mode_on) begin
                     bg_col_q <= nxt_attr[2:0];
                  end
                  cell_b_q <= nxt_attr[3];
               end else if (nxt_code != `OCA_CODE_SPLIT) begin
                  cell_b_q <= nxt_attr[3];
               end
            end
         end else if (walk_q) begin
            dot_q <= dot_q + 5'h01;
            // split space waits for the middle of the cell
            if (split_mid) begin
               if (mode_on) begin
                  bg_col_q <= cell_attr_q[2:0];
               end
               cell_b_q <= cell_attr_q[3];
            end
         end
      end
   end

   // ----------------------------------------
   // pixel output
   // ----------------------------------------
   always @(posedge mclk_i or negedge rst_b) begin
      if (!rst_b) begin
         col_q <= 3'h0;
         ov_q <= 1'b0;
         prev_bit_q <= 1'b0;
      end else begin
         prev_bit_q <= walk_q & cell_bit;
         if (hs_q || vs_q) begin
            col_q <= 3'h0;
            ov_q <= 1'b0;
         end else if (walk_q && !prime_q) begin
            if (cell_bit) begin
               col_q <= cell_attr_q[2:0];
               ov_q <= 1'b1;
            end else if (sh_q && prev_bit_q) begin
               // shadow dot is black whatever the palette
               col_q <= 3'h0;
               ov_q <= 1'b1;
            end else begin
               col_q <= bg_col_q;
               ov_q <= cell_b_q;
            end
         end else begin
            col_q <= bg_col_q;
            ov_q <= 1'b0;
         end
      end
   end

   assign colour_out_bus_o = col_q;
   assign overlay_select_out_o = ov_q;
   assign cg_addr_o = cg_addr_q;

endmodule

// [oca_colour_out_sva.sv]
// checker: register bus handshake, register shadows, sync blanking
// assumes bind onto oca_colour_out, one clock domain
`timescale 1ns/10ps
module oca_colour_out_sva (
   input wire mclk_i,
   input wire rst_b_i,
   input wire [7:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire [31:0] avs_readdata_o,
   input wire avs_waitrequest_o,
   input wire hsync_i,
   input wire vsync_i,
   input wire [2:0] colour_out_bus_o,
   input wire overlay_select_out_o
);
   reg [7:0] attr_q;
   reg [6:0] ptr_q;
   wire wr_ok = avs_write_i && !avs_waitrequest_o;
   wire rd_ok = avs_read_i && !avs_waitrequest_o;
   wire dark = colour_out_bus_o == 3'h0 && !overlay_select_out_o;
   wire known = avs_address_i inside {8'h98, 8'h9A, 8'hA0, 8'hC1};
   // shadows follow accepted writes only, the edge where waitrequest is low
   always @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         attr_q <= 8'h00;
         ptr_q <= 7'h00;
      end else if (wr_ok && avs_address_i == 8'h98)
         attr_q <= avs_writedata_i[7:0];
      else if (wr_ok && avs_address_i == 8'h99)
         ptr_q <= ptr_q + 7'h01;
      else if (wr_ok && avs_address_i == 8'h9A)
         ptr_q <= avs_writedata_i[6:0];
   end
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_b_i);
   // ------------------------------------------------
   // assertions
   // ------------------------------------------------
   AST_WAIT_ONE: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=>
      !avs_waitrequest_o) else $error("no answer");
   AST_WAIT_HI: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("long answer");
   AST_WAIT_IDLE: assert property (!avs_read_i && !avs_write_i |=> avs_waitrequest_o)
      else $error("answer without request");
   AST_RD_ZERO: assert property (rd_ok && !known |-> avs_readdata_o == 32'h0)
      else $error("unmapped read not zero");
   AST_ATTR_RB: assert property (rd_ok && avs_address_i == 8'h98 |-> avs_readdata_o[7:0] == attr_q)
      else $error("attribute readback");
   AST_PTR_RB: assert property (rd_ok && avs_address_i == 8'h9A |-> avs_readdata_o[6:0] == ptr_q)
      else $error("pointer readback");
   AST_HS_BLANK: assert property (hsync_i [*6] |-> dark)
      else $error("colour during hsync");
   AST_VS_BLANK: assert property (vsync_i [*6] |-> dark)
      else $error("colour during vsync");
endmodule
bind oca_colour_out oca_colour_out_sva u_sva (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
   .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .hsync_i(hsync_i), .vsync_i(vsync_i),
   .colour_out_bus_o(colour_out_bus_o), .overlay_select_out_o(overlay_select_out_o));

// [oca_tv_model.sv]
// tv side: glyph rom for the fetch address, tally of dots shown
// assumes the block drives colour and overlay every clock
`timescale 1ns/10ps
module oca_tv_model (
   input wire logic mclk_i,
   input wire logic clr_i,
   input wire logic [10:0] cg_addr_i,
   input wire logic [2:0] colour_i,
   input wire logic overlay_i,
   output logic [13:0] cg_bits_o
);
   int hist [0:15];
   // left seven dots lit; the four special codes draw nothing
   assign cg_bits_o = cg_addr_i[10:5] >= 6'h3C ? 14'h0000 : 14'h3F80;
   // keyed by overlay and colour, so equal colours simply add up
   always @(posedge mclk_i) begin
      if (clr_i)
         hist <= '{default: 0};
      else
         hist[{overlay_i, colour_i}] <= hist[{overlay_i, colour_i}] + 1;
   end
endmodule

// [oca_colour_out_tb.sv]
// bench: register traffic and one displayed row per field
// assumes the checker is bound in and the tv model answers glyph fetches
`timescale 1ns/10ps
module oca_colour_out_tb;
   logic mclk_i, rst_b_i, avs_read_i, avs_write_i, hsync_i, vsync_i, clr;
   logic [7:0] avs_address_i;
   logic [31:0] avs_writedata_i, avs_readdata_o, rd;
   logic avs_waitrequest_o, overlay_select_out_o;
   logic [13:0] cg_bits_i;
   logic [10:0] cg_addr_o;
   logic [2:0] colour_out_bus_o;
   int err_count, compares, attr_m, ptr_m, bg_m, end_m, mode_m, it, lc_m, pb_m;
   int mem_m [0:127];
   int exp_h [0:7];
   oca_colour_out #(.RAM_DEPTH(128)) DUT (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .hsync_i(hsync_i), .vsync_i(vsync_i),
      .cg_bits_i(cg_bits_i), .cg_addr_o(cg_addr_o), .colour_out_bus_o(colour_out_bus_o),
      .overlay_select_out_o(overlay_select_out_o));
   oca_tv_model u_tv (.mclk_i(mclk_i), .clr_i(clr), .cg_addr_i(cg_addr_o),
      .colour_i(colour_out_bus_o), .overlay_i(overlay_select_out_o), .cg_bits_o(cg_bits_i));
   initial begin
      mclk_i = 1'b0;
      forever #2.5 mclk_i = ~mclk_i;
   end
   initial begin
      repeat (40000) @(posedge mclk_i);
      err_count++;
      wrap_up;
   end
   task wrap_up;
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task chk_reg(input logic [31:0] got, input int exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %0t: got %0h want %0h", $time, got, exp);
      end
   endtask
   task chk_cnt(input int got, input int exp);
      chk_reg(got, exp);
   endtask
   task acc(input bit w, input logic [7:0] a, input int d);
      @(posedge mclk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_read_i <= !w;
      avs_write_i <= w;
      // only the watchdog ends a wait that never gets an answer
      do begin
         @(posedge mclk_i);
      end while (avs_waitrequest_o !== 1'b0);
      rd = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input int d);
      acc(1'b1, a, d);
      if (a == 8'h98) attr_m = d;
      if (a == 8'h9A) ptr_m = d;
      if (a == 8'h99) ptr_m = (ptr_m + 1) % 128;
   endtask
   task put(input int at, input int code);
      wr(8'h98, at);
      mem_m[ptr_m] = (at & 8'h17) << 6 | code;
      wr(8'h99, code);
   endtask
   task rchk(input logic [7:0] a, input int exp);
      acc(1'b0, a, 0);
      chk_reg(rd, exp);
   endtask
   // walk of one line: tally of overlay-on dots per colour
   task model_line;
      int v, c, b;
      for (int k = 0; k < 8; k++) exp_h[k] = 0;
      for (int i = 0; i < 128 && mode_m > 0 && end_m == 0; i++) begin
         v = mem_m[i];
         c = v % 64;
         b = v >> 10 & 1;
         if (c == 61) begin
            // the end flag acts once the whole 18-line row is shown
            if (lc_m == 17) end_m = b;
            break;
         end
         if (c == 63 && pb_m) exp_h[bg_m] += 7;
         if (c >= 62) bg_m = v >> 6 & 7;
         if (c < 60) exp_h[v >> 6 & 7] += 7;
         if (b) exp_h[bg_m] += c < 60 || c == 63 ? 7 : 14;
         pb_m = b;
      end
      lc_m++;
   endtask
   task line;
      model_line;
      @(posedge mclk_i);
      clr <= 1'b1;
      hsync_i <= 1'b0;
      @(posedge mclk_i);
      clr <= 1'b0;
      repeat (100) @(posedge mclk_i);
      hsync_i <= 1'b1;
      repeat (8) @(posedge mclk_i);
      for (int k = 0; k < 8; k++) chk_cnt(u_tv.hist[8 + k], exp_h[k]);
   endtask
   task vpulse;
      @(posedge mclk_i);
      vsync_i <= 1'b1;
      repeat (8) @(posedge mclk_i);
      vsync_i <= 1'b0;
      repeat (8) @(posedge mclk_i);
      end_m = 0;
      lc_m = 0;
   endtask
   initial begin
      rst_b_i = 1'b0;
      avs_read_i = 1'b0;
      avs_write_i = 1'b0;
      avs_address_i = 8'h00;
      avs_writedata_i = 32'h0;
      hsync_i = 1'b1;
      vsync_i = 1'b0;
      clr = 1'b0;
      void'($urandom(32'hC810E6B1));
      repeat (3) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      // mode 0 first: display off, so the colour space must not land
      for (it = 0; it < 4; it++) begin
         wr(8'hC1, it << 4);
         mode_m = it;
         wr(8'h9A, 0);
         put(8'h10 | ($urandom & 8'hE8) | $urandom % 2 * 7, 6'h3E);
         put($urandom % 256, $urandom % 60);
         put($urandom % 256, 6'h3C);
         put(($urandom & 8'hF8) | $urandom % 2 * 7, 6'h3F);
         put(8'h10 | ($urandom & 8'hE8), 6'h3D);
         rchk(8'h98, attr_m);
         rchk(8'h9A, ptr_m);
         rchk(8'h99, 0);
         rchk(8'h55, 0);
         rchk(8'hC1, it << 4);
         vpulse;
         rchk(8'hA0, 8 | bg_m);
         // one full row plus one line, so the end flag shows
         repeat (19) line;
         rchk(8'hA0, end_m << 5 | 8 | bg_m);
      end
      wrap_up;
   end
endmodule
